/* File: tmc_pkg.sv */
// ********************************************************************
// Constants shared by the dual timer/counter control block.
// ********************************************************************
package tmc_pkg;

   // ********************************************************************
   // Register indices and byte addresses on the Avalon-MM slave.
   // ********************************************************************
   // Each index is one 32-bit word; the byte address is four times it.
   localparam logic [7:0] IDX_TIMER3_CONTROL = 8'h27;
   localparam logic [7:0] IDX_TIMER4_CONTROL = 8'h28;
   localparam logic [7:0] IDX_TIMER3_PERIOD = 8'h2A;
   localparam logic [7:0] IDX_TIMER3_PULSE = 8'h2B;
   localparam logic [7:0] IDX_TIMER4_PERIOD = 8'h2C;
   localparam logic [7:0] IDX_TIMER4_PULSE = 8'h2D;
   localparam logic [7:0] IDX_STATUS = 8'h2E;
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] ADDR_TIMER3_CONTROL = 8'(IDX_TIMER3_CONTROL * 4);
   localparam logic [ADDR_W-1:0] ADDR_TIMER4_CONTROL = 8'(IDX_TIMER4_CONTROL * 4);
   localparam logic [ADDR_W-1:0] ADDR_TIMER3_PERIOD = 8'(IDX_TIMER3_PERIOD * 4);
   localparam logic [ADDR_W-1:0] ADDR_TIMER3_PULSE = 8'(IDX_TIMER3_PULSE * 4);
   localparam logic [ADDR_W-1:0] ADDR_TIMER4_PERIOD = 8'(IDX_TIMER4_PERIOD * 4);
   localparam logic [ADDR_W-1:0] ADDR_TIMER4_PULSE = 8'(IDX_TIMER4_PULSE * 4);
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'(IDX_STATUS * 4);

   // ********************************************************************
   // Control register field layout and reset values.
   // ********************************************************************
   localparam int CTL_FF_BIT = 7;
   localparam int CTL_CLK_MSB = 6;
   localparam int CTL_CLK_LSB = 4;
   localparam int CTL_RUN_BIT = 3;
   localparam int CTL_MODE_MSB = 2;
   localparam int CTL_MODE_LSB = 0;
   localparam logic [7:0] CTL_RESET = 8'h00;
   localparam logic [7:0] TREG_RESET = 8'h00;

   // Status word bit positions.
   localparam int STAT_RUN3_BIT = 0;
   localparam int STAT_RUN4_BIT = 1;
   localparam int STAT_OUT3_BIT = 2;
   localparam int STAT_OUT4_BIT = 3;
   localparam int STAT_CASC_BIT = 4;
   localparam int STAT_CNT3_LSB = 8;
   localparam int STAT_CNT4_LSB = 16;

   // ********************************************************************
   // Encodings.
   // ********************************************************************
   typedef enum logic [2:0] {
      MODE_TIMER = 3'b000,
      MODE_PDO = 3'b001,
      MODE_PWM8 = 3'b010,
      MODE_CASCADE = 3'b011,
      MODE_TIMER16 = 3'b100,
      MODE_WARMUP = 3'b101,
      MODE_PWM16 = 3'b110,
      MODE_PPG16 = 3'b111
   } tmc_mode_t;

   typedef enum logic [2:0] {
      CLK_DIV11 = 3'b000,
      CLK_DIV7 = 3'b001,
      CLK_DIV5 = 3'b010,
      CLK_DIV3 = 3'b011,
      CLK_SUB = 3'b100,
      CLK_DIV1 = 3'b101,
      CLK_MAIN = 3'b110,
      CLK_PIN = 3'b111
   } tmc_clk_t;

   // Divider tap indices on the prescaler tick vector.
   localparam int TAP_DIV1 = 0;
   localparam int TAP_DIV3 = 1;
   localparam int TAP_DIV5 = 2;
   localparam int TAP_DIV7 = 3;
   localparam int TAP_DIV11 = 4;
   localparam int NUM_TAPS = 5;
   localparam logic [2:0] SUB_DIV_LAST = 3'h7;

endpackage : tmc_pkg

/* File: tmc_prescaler.sv */
`timescale 1ns/10ps
// ********************************************************************
// Free-running prescaler producing one-cycle divided ticks.
// ********************************************************************
module tmc_prescaler
   import tmc_pkg::*;
#(
   parameter int DIV_W = 11
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic subClkTick,
   output logic [NUM_TAPS-1:0] mainTicks,
   output logic subDiv3Tick
);

   // Tap k of the main divider fires every 2^TAP_SHIFT[k] reference cycles (2, 8, 32, 128, 2048).
   localparam int TAP_SHIFT [NUM_TAPS] = '{1, 3, 5, 7, 11};

   logic [DIV_W-1:0] divCnt_ff;
   logic [2:0] subCnt_ff;
   logic subDiv3Tick_ff;
   logic [NUM_TAPS-1:0] mainTicks_ff;

   // Main divider counts every reference clock edge.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         divCnt_ff <= '0;
      end else begin
         divCnt_ff <= divCnt_ff + 1'b1;
      end
   end

   // A tap ticks when its low bits are all ones; registered for clean fan-out.
   genvar gi;
   generate
      for (gi = 0; gi < NUM_TAPS; gi++) begin : g_tap
         always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
               mainTicks_ff[gi] <= 1'b0;
            end else begin
               mainTicks_ff[gi] <= &divCnt_ff[TAP_SHIFT[gi]-1:0];
            end
         end
      end
   endgenerate

   // Low-frequency clock divided by eight, counted on its strobes.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         subCnt_ff <= '0;
         subDiv3Tick_ff <= 1'b0;
      end else begin
         subDiv3Tick_ff <= subClkTick && (subCnt_ff == SUB_DIV_LAST);
         if (subClkTick) begin
            subCnt_ff <= subCnt_ff + 1'b1;
         end
      end
   end

   assign mainTicks = mainTicks_ff;
   assign subDiv3Tick = subDiv3Tick_ff;

endmodule : tmc_prescaler

/* File: tmc_timer_ctrl.sv */
`timescale 1ns/10ps
// ********************************************************************
// Dual 8-bit timer/counter control with 16-bit cascade.
// ********************************************************************
// Overview of operation
// - Control plus period and pulse registers each
// - First control register resets to zero
// - Run 0 stops and clears; 1 counts
// - Normal/idle clock select decode, eight sources
// - Slow/sleep: low clock, pin; main warm-up
// - Mode 001 divider, 010 PWM (runs as 001 here, pulse register unused), 011 cascade
// - Mode 000 is the plain timer/counter (runs as 001 here, output toggles on match)
// - Cascade: first mode 011, second selects
// - Cascade clock from first, run/flop second
module tmc_timer_ctrl
   import tmc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic subClkTick,
   input wire logic slowMode,
   input wire logic prescalerSlowSelect,
   input wire logic timer3Pin,
   input wire logic timer4Pin,
   output logic timer3Out,
   output logic timer4Out
);

   // ********************************************************************
   // Declarations.
   // ********************************************************************
   logic [7:0] timer3Control_ff;
   logic [7:0] timer4Control_ff;
   logic [7:0] timer3PeriodReg_ff;
   logic [7:0] timer3PulseWidthReg_ff;
   logic [7:0] timer4PeriodReg_ff;
   logic [7:0] timer4PulseWidthReg_ff;
   logic [7:0] count3_ff;
   logic [7:0] count4_ff;
   logic run3Prev_ff;
   logic run4Prev_ff;
   logic timer3Out_ff;
   logic timer4Out_ff;
   logic pin3Prev_ff;
   logic pin4Prev_ff;
   logic waitrequest_ff;
   logic [31:0] readdata_ff;
   logic [31:0] nxt_readdata;
   logic [NUM_TAPS-1:0] mainTicks;
   logic subDiv3Tick;
   logic cascade;
   logic warmUp;
   logic run3;
   logic run4;
   logic ffCtl3;
   logic ffCtl4;
   logic tick3;
   logic tick4;
   logic match3;
   logic match4;
   logic match16;
   logic [15:0] count16;
   logic [15:0] nxt_count16;
   logic wrAccept;

   // ********************************************************************
   // Source clock selection.
   // ********************************************************************
   // Decodes a 3-bit clock select into a one-cycle count strobe. The slow
   // power modes keep only the low clock and pin sources; the main clock
   // there is granted solely to the warm-up counter.
   function automatic logic srcTick(
      input logic [2:0] sel,
      input logic slow,
      input logic dvSel,
      input logic warm,
      input logic [NUM_TAPS-1:0] taps,
      input logic subDiv,
      input logic subTick,
      input logic pinRise
   );
      logic t;
      t = 1'b0;
      if (slow) begin
         unique case (sel)
            CLK_DIV11: t = subDiv;
            CLK_SUB: t = subTick;
            CLK_MAIN: t = warm;
            CLK_PIN: t = pinRise;
            default: t = 1'b0;
         endcase
      end else begin
         unique case (sel)
            CLK_DIV11: t = dvSel ? subDiv : taps[TAP_DIV11];
            CLK_DIV7: t = taps[TAP_DIV7];
            CLK_DIV5: t = taps[TAP_DIV5];
            CLK_DIV3: t = taps[TAP_DIV3];
            CLK_SUB: t = subTick;
            CLK_DIV1: t = taps[TAP_DIV1];
            CLK_MAIN: t = 1'b1;
            CLK_PIN: t = pinRise;
         endcase
      end
      return t;
   endfunction : srcTick

   tmc_prescaler #(
      .DIV_W(11)
   ) u_prescaler (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .subClkTick(subClkTick),
      .mainTicks(mainTicks),
      .subDiv3Tick(subDiv3Tick)
   );

   // Pin inputs are synchronous; only their rising edges count.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pin3Prev_ff <= 1'b0;
         pin4Prev_ff <= 1'b0;
      end else begin
         pin3Prev_ff <= timer3Pin;
         pin4Prev_ff <= timer4Pin;
      end
   end

   // ********************************************************************
   // Mode, run and clock routing.
   // ********************************************************************
   // In cascade the first timer only lends its clock select; run and the
   // output flop control are taken from the second timer.
   assign cascade = (timer3Control_ff[CTL_MODE_MSB:CTL_MODE_LSB] == MODE_CASCADE);
   assign warmUp = cascade && (timer4Control_ff[CTL_MODE_MSB:CTL_MODE_LSB] == MODE_WARMUP);
   assign run4 = timer4Control_ff[CTL_RUN_BIT];
   assign run3 = cascade ? run4 : timer3Control_ff[CTL_RUN_BIT];
   assign ffCtl4 = timer4Control_ff[CTL_FF_BIT];
   assign ffCtl3 = cascade ? ffCtl4 : timer3Control_ff[CTL_FF_BIT];
   assign tick3 = srcTick(timer3Control_ff[CTL_CLK_MSB:CTL_CLK_LSB], slowMode, prescalerSlowSelect,
                          warmUp, mainTicks, subDiv3Tick, subClkTick, timer3Pin && !pin3Prev_ff);
   assign tick4 = srcTick(timer4Control_ff[CTL_CLK_MSB:CTL_CLK_LSB], slowMode, prescalerSlowSelect,
                          1'b0, mainTicks, subDiv3Tick, subClkTick, timer4Pin && !pin4Prev_ff);

   // Compare values; the cascade pair compares as one 16-bit word.
   assign count16 = {count4_ff, count3_ff};
   assign match3 = (count3_ff == timer3PeriodReg_ff);
   assign match4 = (count4_ff == timer4PeriodReg_ff);
   assign match16 = (count16 == {timer4PeriodReg_ff, timer3PeriodReg_ff});
   assign nxt_count16 = match16 ? 16'h0000 : count16 + 16'h0001;

   // ********************************************************************
   // Counters.
   // ********************************************************************
   // A cleared run bit holds the counter at zero; the period match wraps it.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         count3_ff <= 8'h00;
         count4_ff <= 8'h00;
      end else if (cascade) begin
         if (!run4) begin
            count3_ff <= 8'h00;
            count4_ff <= 8'h00;
         end else if (tick3) begin
            count3_ff <= nxt_count16[7:0];
            count4_ff <= nxt_count16[15:8];
         end
      end else begin
         if (!run3) begin
            count3_ff <= 8'h00;
         end else if (tick3) begin
            count3_ff <= match3 ? 8'h00 : count3_ff + 8'h01;
         end
         if (!run4) begin
            count4_ff <= 8'h00;
         end else if (tick4) begin
            count4_ff <= match4 ? 8'h00 : count4_ff + 8'h01;
         end
      end
   end

   // ********************************************************************
   // Output flip-flops.
   // ********************************************************************
   // On a start edge the flop takes its control bit; afterwards it toggles
   // on each period match, giving the divider output waveform.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         run3Prev_ff <= 1'b0;
         run4Prev_ff <= 1'b0;
         timer3Out_ff <= 1'b0;
         timer4Out_ff <= 1'b0;
      end else begin
         run3Prev_ff <= run3;
         run4Prev_ff <= run4;
         if (run3 && !run3Prev_ff) begin
            timer3Out_ff <= ffCtl3;
         end else if (run3 && tick3 && (cascade ? match16 : match3)) begin
            timer3Out_ff <= !timer3Out_ff;
         end
         if (run4 && !run4Prev_ff) begin
            timer4Out_ff <= ffCtl4;
         end else if (run4 && (cascade ? (tick3 && match16) : (tick4 && match4))) begin
            timer4Out_ff <= !timer4Out_ff;
         end
      end
   end

   assign timer3Out = timer3Out_ff;
   assign timer4Out = timer4Out_ff;

   // ********************************************************************
   // Avalon-MM slave handshake.
   // ********************************************************************
   // Waitrequest rests high and drops for exactly one cycle per request,
   // so every access completes one edge after it is first seen.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         waitrequest_ff <= 1'b1;
      end else if (!waitrequest_ff) begin
         waitrequest_ff <= 1'b1;
      end else if (read || write) begin
         waitrequest_ff <= 1'b0;
      end
   end

   assign wrAccept = write && !waitrequest_ff && byteenable[0];
   assign waitrequest = waitrequest_ff;

   // ********************************************************************
   // Register file.
   // ********************************************************************
   // Writes land at the completing edge. Mode, clock and flop fields are
   // stored as written; software is trusted to hold them while running.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         timer3Control_ff <= CTL_RESET;
         timer4Control_ff <= CTL_RESET;
      end else if (wrAccept && (address == ADDR_TIMER3_CONTROL)) begin
         timer3Control_ff <= writedata[7:0];
      end else if (wrAccept && (address == ADDR_TIMER4_CONTROL)) begin
         timer4Control_ff <= writedata[7:0];
      end
   end

   // Timer registers: period and pulse width for each timer.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         timer3PeriodReg_ff <= TREG_RESET;
         timer3PulseWidthReg_ff <= TREG_RESET;
         timer4PeriodReg_ff <= TREG_RESET;
         timer4PulseWidthReg_ff <= TREG_RESET;
      end else if (wrAccept) begin
         unique case (address)
            ADDR_TIMER3_PERIOD: timer3PeriodReg_ff <= writedata[7:0];
            ADDR_TIMER3_PULSE: timer3PulseWidthReg_ff <= writedata[7:0];
            ADDR_TIMER4_PERIOD: timer4PeriodReg_ff <= writedata[7:0];
            ADDR_TIMER4_PULSE: timer4PulseWidthReg_ff <= writedata[7:0];
            default: ;
         endcase
      end
   end

   // Read mux; unmapped addresses read as zero.
   always_comb begin
      nxt_readdata = 32'h0000_0000;
      unique case (address)
         ADDR_TIMER3_CONTROL: nxt_readdata[7:0] = timer3Control_ff;
         ADDR_TIMER4_CONTROL: nxt_readdata[7:0] = timer4Control_ff;
         ADDR_TIMER3_PERIOD: nxt_readdata[7:0] = timer3PeriodReg_ff;
         ADDR_TIMER3_PULSE: nxt_readdata[7:0] = timer3PulseWidthReg_ff;
         ADDR_TIMER4_PERIOD: nxt_readdata[7:0] = timer4PeriodReg_ff;
         ADDR_TIMER4_PULSE: nxt_readdata[7:0] = timer4PulseWidthReg_ff;
         ADDR_STATUS: begin
            nxt_readdata[STAT_RUN3_BIT] = run3;
            nxt_readdata[STAT_RUN4_BIT] = run4;
            nxt_readdata[STAT_OUT3_BIT] = timer3Out_ff;
            nxt_readdata[STAT_OUT4_BIT] = timer4Out_ff;
            nxt_readdata[STAT_CASC_BIT] = cascade;
            nxt_readdata[STAT_CNT3_LSB +: 8] = count3_ff;
            nxt_readdata[STAT_CNT4_LSB +: 8] = count4_ff;
         end
         default: nxt_readdata = 32'h0000_0000;
      endcase
   end

   // Read data is captured when the request is first seen and then holds,
   // so it stands at the edge where waitrequest is sampled low.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         readdata_ff <= 32'h0000_0000;
      end else if (read && waitrequest_ff) begin
         readdata_ff <= nxt_readdata;
      end
   end

   assign readdata = readdata_ff;

endmodule : tmc_timer_ctrl

/* File: tmc_timer_ctrl_assertions.sv */
`timescale 1ns/10ps
// ****
// Port checks for the timer control block.
// ****
module tmc_timer_ctrl_assertions
   import tmc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] writedata,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   input wire logic subClkTick,
   input wire logic slowMode,
   input wire logic prescalerSlowSelect,
   input wire logic timer3Pin,
   input wire logic timer4Pin,
   input wire logic timer3Out,
   input wire logic timer4Out
);
   logic [7:0] shadowCtl3_ff;
   logic [7:0] shadowCtl4_ff;
   logic acc3;
   logic acc4;
   logic mapped;

   // Accepted control writes, decoded so start edges can be recognised.
   assign acc3 = write && !waitrequest && byteenable[0] && (address == ADDR_TIMER3_CONTROL);
   assign acc4 = write && !waitrequest && byteenable[0] && (address == ADDR_TIMER4_CONTROL);
   assign mapped = address inside {ADDR_TIMER3_CONTROL, ADDR_TIMER4_CONTROL, ADDR_TIMER3_PERIOD,
      ADDR_TIMER3_PULSE, ADDR_TIMER4_PERIOD, ADDR_TIMER4_PULSE, ADDR_STATUS};

   // Mirror of the control registers; the run state is not visible at the ports otherwise.
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         shadowCtl3_ff <= 8'h00;
         shadowCtl4_ff <= 8'h00;
      end else begin
         if (acc3) begin
            shadowCtl3_ff <= writedata[7:0];
         end
         if (acc4) begin
            shadowCtl4_ff <= writedata[7:0];
         end
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   // ****
   // Assertions.
   // ****
   chk_wait_one_cycle: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("access not answered after one wait cycle");
   chk_wait_low_pulse: assert property (!waitrequest |=> waitrequest)
      else $error("waitrequest low for more than one cycle");
   chk_wait_has_cause: assert property (!waitrequest |-> $past(read || write) && $past(waitrequest))
      else $error("waitrequest low without a request");
   chk_idle_no_answer: assert property (!read && !write |=> waitrequest)
      else $error("answer given with no request");
   chk_reset_state: assert property (disable iff (1'b0)
      !rst_n |=> waitrequest && (readdata == 32'h0) && !timer3Out && !timer4Out)
      else $error("outputs not idle after reset");
   chk_unmapped_read: assert property (read && waitrequest && !mapped |=> readdata == 32'h0)
      else $error("unmapped read returned nonzero data");
   chk_read_data_hold: assert property (!read |=> $stable(readdata))
      else $error("read data changed without a read");
   chk_start_flop3: assert property (acc3 && writedata[CTL_RUN_BIT] && !shadowCtl3_ff[CTL_RUN_BIT]
      && (writedata[2:0] != 3'b011) |-> ##2 (timer3Out == $past(writedata[CTL_FF_BIT], 2)))
      else $error("first output not loaded from control bit on start");
   chk_start_flop4: assert property (acc4 && writedata[CTL_RUN_BIT] && !shadowCtl4_ff[CTL_RUN_BIT]
      && (shadowCtl3_ff[2:0] != 3'b011) |-> ##2 (timer4Out == $past(writedata[CTL_FF_BIT], 2)))
      else $error("second output not loaded from control bit on start");
   chk_stopped_holds: assert property (!shadowCtl3_ff[CTL_RUN_BIT] && (shadowCtl3_ff[2:0] != 3'b011)
      && !acc3 |=> $stable(timer3Out))
      else $error("first output moved while stopped");

   // Main scenarios reached.
   cov_start: cover property (acc3 && writedata[CTL_RUN_BIT]);
   cov_cascade: cover property (acc3 && (writedata[2:0] == 3'b011));
   cov_status: cover property (read && !waitrequest && (address == ADDR_STATUS));
endmodule : tmc_timer_ctrl_assertions

bind tmc_timer_ctrl tmc_timer_ctrl_assertions u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .address(address),
   .read(read), .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
   .waitrequest(waitrequest), .subClkTick(subClkTick), .slowMode(slowMode),
   .prescalerSlowSelect(prescalerSlowSelect), .timer3Pin(timer3Pin), .timer4Pin(timer4Pin),
   .timer3Out(timer3Out), .timer4Out(timer4Out));

/* File: tmc_timer_ctrl_test.sv */
`timescale 1ns/10ps
// ****
// Self-checking bench for the timer control block.
// ****
module tmc_timer_ctrl_test
   import tmc_pkg::*;
;
   logic ref_clk, rst_n, read, write, waitrequest, subClkTick, slowMode, prescalerSlowSelect;
   logic timer3Pin, timer4Pin, timer3Out, timer4Out;
   logic [ADDR_W-1:0] address;
   logic [3:0] byteenable;
   logic [31:0] writedata, readdata, rd;
   int nFail, samplesChecked, cycles;
   logic [7:0] regs [6] = '{ADDR_TIMER3_CONTROL, ADDR_TIMER4_CONTROL, ADDR_TIMER3_PERIOD,
      ADDR_TIMER3_PULSE, ADDR_TIMER4_PERIOD, ADDR_TIMER4_PULSE};

   tmc_timer_ctrl u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .address(address), .read(read),
      .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .subClkTick(subClkTick), .slowMode(slowMode),
      .prescalerSlowSelect(prescalerSlowSelect), .timer3Pin(timer3Pin), .timer4Pin(timer4Pin),
      .timer3Out(timer3Out), .timer4Out(timer4Out));

   // Free-running clock and a watchdog so a stuck handshake cannot hang the run.
   initial ref_clk = 1'b0;
   always #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 40000) begin
         nFail++;
         stop_test();
      end
   end

   // ****
   // Shared tasks.
   // ****
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samplesChecked++;
      if (seen !== exp) begin
         nFail++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // One bus access; the request stands until waitrequest is seen low, whatever the latency.
   task bus(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic [3:0] be);
      @(posedge ref_clk);
      address <= a;
      writedata <= {24'h0, d};
      byteenable <= be;
      read <= !wr;
      write <= wr;
      do begin
         @(posedge ref_clk);
      end while (waitrequest !== 1'b0);
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask : bus

   task wr(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, a, d, 4'hF);
   endtask : wr

   task rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 8'h00, 4'hF);
      check(what, rd, exp);
   endtask : rdc

   // Pin edges are spaced out so each one is seen as a single rising edge.
   task pins(input int n);
      repeat (n) begin
         @(posedge ref_clk);
         timer3Pin <= 1'b1;
         timer4Pin <= 1'b1;
         repeat (2) @(posedge ref_clk);
         timer3Pin <= 1'b0;
         timer4Pin <= 1'b0;
         repeat (2) @(posedge ref_clk);
      end
   endtask : pins

   task subTicks(input int n);
      repeat (n) begin
         @(posedge ref_clk);
         subClkTick <= 1'b1;
         @(posedge ref_clk);
         subClkTick <= 1'b0;
      end
   endtask : subTicks

   // ****
   // Scenarios.
   // ****
   task t_reset();
      for (int i = 0; i < 6; i++) rdc("reset value", regs[i], 32'h0);
      rdc("reset status", ADDR_STATUS, 32'h0);
   endtask : t_reset

   task t_regs();
      for (int i = 0; i < 6; i++) wr(regs[i], 8'h50 | 8'(i));
      for (int i = 0; i < 6; i++) rdc("register", regs[i], 32'h50 | i);
      bus(1'b1, ADDR_TIMER3_PULSE, 8'h3C, 4'hE);
      rdc("disabled lane", ADDR_TIMER3_PULSE, 32'h53);
      wr(8'h04, 8'hFF);
      rdc("unmapped", 8'h04, 32'h0);
      for (int m = 0; m < 4; m++) begin
         wr(ADDR_TIMER3_CONTROL, 8'(m));
         rdc("mode field", ADDR_TIMER3_CONTROL, m);
         bus(1'b0, ADDR_STATUS, 8'h00, 4'hF);
         check("cascade flag", rd[STAT_CASC_BIT], m == 3);
      end
      wr(ADDR_TIMER3_CONTROL, 8'h00);
      wr(ADDR_TIMER4_CONTROL, 8'h00);
   endtask : t_regs

   task t_start();
      logic [7:0] ca;
      for (int tm = 0; tm < 2; tm++) begin
         for (int f = 0; f < 2; f++) begin
            ca = tm ? ADDR_TIMER4_CONTROL : ADDR_TIMER3_CONTROL;
            wr(tm ? ADDR_TIMER4_PERIOD : ADDR_TIMER3_PERIOD, 8'h0A);
            wr(ca, {f[0], 3'b111, 1'b1, 3'b000});
            repeat (2) @(posedge ref_clk);
            check("output on start", tm ? timer4Out : timer3Out, f);
            pins(3);
            bus(1'b0, ADDR_STATUS, 8'h00, 4'hF);
            check("pin count", rd[8 + 8 * tm +: 8], 32'h3);
            check("run flag", rd[tm], 1'b1);
            wr(ca, {f[0], 3'b111, 1'b0, 3'b000});
            bus(1'b0, ADDR_STATUS, 8'h00, 4'hF);
            check("count after stop", rd[8 + 8 * tm +: 8], 32'h0);
         end
      end
   endtask : t_start

   task t_clocks();
      logic [2:0] codes [5] = '{3'b001, 3'b010, 3'b011, 3'b101, 3'b110};
      wr(ADDR_TIMER3_PERIOD, 8'hFF);
      for (int s = 0; s < 2; s++) begin
         slowMode <= s[0];
         prescalerSlowSelect <= !s[0];
         for (int i = 0; i < 5; i++) begin
            wr(ADDR_TIMER3_CONTROL, {1'b0, codes[i], 1'b1, 3'b000});
            repeat (300) @(posedge ref_clk);
            bus(1'b0, ADDR_STATUS, 8'h00, 4'hF);
            check("fast source ticks", |rd[15:8], !s[0]);
            wr(ADDR_TIMER3_CONTROL, {1'b0, codes[i], 1'b0, 3'b000});
         end
         wr(ADDR_TIMER3_CONTROL, 8'h48);
         subTicks(3);
         rdc("low clock count", ADDR_STATUS, 32'h0309);
         wr(ADDR_TIMER3_CONTROL, 8'h40);
         wr(ADDR_TIMER3_CONTROL, 8'h08);
         subTicks(16);
         rdc("low clock by 8 count", ADDR_STATUS, 32'h0209);
         wr(ADDR_TIMER3_CONTROL, 8'h00);
      end
      // Code 000 in normal mode with the main clock divided by 2048.
      slowMode <= 1'b0;
      prescalerSlowSelect <= 1'b0;
      wr(ADDR_TIMER3_CONTROL, 8'h08);
      repeat (2100) @(posedge ref_clk);
      bus(1'b0, ADDR_STATUS, 8'h00, 4'hF);
      check("main clock by 2048 ticks", |rd[15:8], 1'b1);
      wr(ADDR_TIMER3_CONTROL, 8'h00);
   endtask : t_clocks

   task t_cascade();
      slowMode <= 1'b1;
      wr(ADDR_TIMER4_PERIOD, 8'hFF);
      wr(ADDR_TIMER3_CONTROL, {1'b0, 3'b110, 1'b0, 3'b011});
      wr(ADDR_TIMER4_CONTROL, {1'b1, 3'b000, 1'b1, 3'b101});
      repeat (20) @(posedge ref_clk);
      bus(1'b0, ADDR_STATUS, 8'h00, 4'hF);
      check("warm-up ticks", |rd[15:8], 1'b1);
      check("cascade run", {rd[STAT_CASC_BIT], rd[STAT_RUN4_BIT]}, 2'b11);
      check("second output", timer4Out, 1'b1);
      wr(ADDR_TIMER4_CONTROL, {1'b1, 3'b000, 1'b0, 3'b101});
      slowMode <= 1'b0;
      wr(ADDR_TIMER3_CONTROL, {1'b0, 3'b111, 1'b0, 3'b011});
      wr(ADDR_TIMER4_CONTROL, {1'b0, 3'b000, 1'b1, 3'b100});
      repeat (2) @(posedge ref_clk);
      check("second output", timer4Out, 1'b0);
      pins(2);
      bus(1'b0, ADDR_STATUS, 8'h00, 4'hF);
      check("cascade pin count", rd[15:8], 32'h2);
      wr(ADDR_TIMER4_CONTROL, {1'b0, 3'b000, 1'b0, 3'b100});
      wr(ADDR_TIMER3_CONTROL, 8'h00);
   endtask : t_cascade

   task stop_test();
      $display("checks %0d mismatches %0d", samplesChecked, nFail);
      if (nFail == 0 && samplesChecked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : stop_test

   // Main sequence: hold reset for three edges, then run every scenario in turn.
   initial begin
      {read, write, subClkTick, slowMode, prescalerSlowSelect, timer3Pin, timer4Pin} = '0;
      address = '0;
      byteenable = '0;
      writedata = '0;
      rst_n = 1'b0;
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_reset();
      t_regs();
      t_start();
      t_clocks();
      t_cascade();
      stop_test();
   end
endmodule : tmc_timer_ctrl_test
